// ===== rom_flash_access_timing.sv
// rom/flash chip select timing: speed modes, wait states, bursts, events
module rom_flash_access_timing #(
  parameter int NUM_SEL = 3
) (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  // chip setup register port
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_index,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  // cpu side
  input  wire rom_timing_pkg::cpu_req_t cpu_req,
  input  wire logic                    cpu_cache_en,
  output logic                         cpu_ready,
  // external pins
  input  wire logic                    iochrdy_pin,
  output logic [NUM_SEL-1:0]           rom_chip_select_n,
  output logic                         rom_read_strobe,
  output logic                         rom_write_strobe,
  output logic [3:0]                   system_address_low,
  output logic                         wide_buffer_output_enable,
  // power management
  output logic                         rom_access_event,
  output logic                         rom_clk_enable
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_WAIT, ST_STROBE, ST_NEXT, ST_DONE
  } phase_t;

  typedef struct packed {
    rom_timing_pkg::sel_cfg_t [NUM_SEL-1:0] cfg;
    phase_t                  phase;
    logic [1:0]              sel;
    logic                    write;
    logic                    fast;
    logic                    early;
    logic                    burst;
    logic                    hold;
    logic [3:0]              addr;
    logic [3:0]              beat_left;
    logic [4:0]              cnt;
    logic [1:0]              div;
    logic [1:0]              rdy_s1;
    logic                    rdy_s2;
    logic [NUM_SEL-1:0]      cs_n;
    logic                    rd;
    logic                    wr;
    logic                    done;
    logic                    event_out;
    logic                    qual_prev;
    logic                    wide_oe;
    logic [7:0]              rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_wide(input logic [7:0] a);
    is_wide = (a[rom_timing_pkg::A_WIDTH_LO +: 2] ==
               rom_timing_pkg::WIDTH_32);
  endfunction

  function automatic logic is_fast(input logic [7:0] a);
    is_fast = a[rom_timing_pkg::A_FAST] | is_wide(a);
  endfunction

  function automatic logic is_narrow(input logic [7:0] a);
    is_narrow = !is_wide(a);
  endfunction

  // wait count for the access now starting
  function automatic logic [4:0] wait_of(input logic [7:0] b,
                                         input logic       later_burst);
    if (later_burst) begin
      wait_of = {1'b0, b[rom_timing_pkg::B_BURST_LO +: 4]};
    end else begin
      wait_of = {1'b0, b[rom_timing_pkg::B_FIRST_LO +: 4]};
    end
  endfunction

  localparam logic [4:0] NORMAL_LEN  = 5'(rom_timing_pkg::NORMAL_CYC);
  localparam logic [1:0] FAST_DIV_M1 = 2'(rom_timing_pkg::FAST_DIV - 1);
  localparam logic [4:0] BURST_MIN   = 5'(rom_timing_pkg::BURST_MIN_CYC);

  logic [7:0] cur_a;
  logic [7:0] cur_b;
  logic       rom_edge;
  logic       qual_now;
  logic       any_wide;

  always_comb begin
    cur_a    = s_r.cfg[s_r.sel].cfg_a;
    cur_b    = s_r.cfg[s_r.sel].cfg_b;
    rom_edge = (s_r.div == '0);
    any_wide = is_wide(s_r.cfg[0].cfg_a);
    qual_now = (s_r.cs_n != '1) && (s_r.rd || s_r.wr);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt           = s_r;
    s_nxt.done      = 1'b0;
    s_nxt.rdy_s1    = {s_r.rdy_s1[0], iochrdy_pin};
    s_nxt.rdy_s2    = s_r.rdy_s1[1];
    s_nxt.qual_prev = qual_now;
    s_nxt.event_out = qual_now && !s_r.qual_prev;
    s_nxt.div       = (s_r.div == FAST_DIV_M1) ? 2'h0 : s_r.div + 2'h1;

    // register port
    if (reg_wr) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        if (reg_index == rom_timing_pkg::IDX_SEL0_A + 8'(2 * i)) begin
          s_nxt.cfg[i].cfg_a = reg_wdata;
        end else if (reg_index == rom_timing_pkg::IDX_SEL0_B + 8'(2 * i))
        begin
          s_nxt.cfg[i].cfg_b = reg_wdata;
        end
      end
    end
    s_nxt.rdata = 8'h00;
    for (int i = 0; i < NUM_SEL; i++) begin
      if (reg_index == rom_timing_pkg::IDX_SEL0_A + 8'(2 * i)) begin
        s_nxt.rdata = s_r.cfg[i].cfg_a;
      end else if (reg_index == rom_timing_pkg::IDX_SEL0_B + 8'(2 * i)) begin
        s_nxt.rdata = s_r.cfg[i].cfg_b;
      end
    end

    case (s_r.phase)
      ST_IDLE: begin
        s_nxt.cs_n = '1;
        s_nxt.rd   = 1'b0;
        s_nxt.wr   = 1'b0;
        if (cpu_req.valid && !cpu_req.isa) begin
          s_nxt.sel   = cpu_req.sel;
          s_nxt.write = cpu_req.write;
          s_nxt.addr  = cpu_req.addr_low;
          s_nxt.fast  = is_fast(s_r.cfg[cpu_req.sel].cfg_a);
          s_nxt.early = s_r.cfg[cpu_req.sel].cfg_a[rom_timing_pkg::A_EARLY];
          s_nxt.burst = cpu_req.line_fill && !cpu_req.write &&
                        (cpu_req.addr_low == 4'h0) &&
                        s_r.cfg[cpu_req.sel].cfg_a[rom_timing_pkg::A_BURST];
          s_nxt.hold  = !cpu_req.write && cpu_req.cacheable &&
                        cpu_cache_en && (cpu_req.addr_low[1:0] == 2'b00) &&
                        is_narrow(s_r.cfg[cpu_req.sel].cfg_a);
          s_nxt.beat_left = cpu_req.line_fill ? 4'hf :
                            {2'b00, 2'b11};
          s_nxt.phase = ST_SETUP;
          if (s_r.cfg[cpu_req.sel].cfg_a[rom_timing_pkg::A_EARLY]) begin
            s_nxt.cs_n[cpu_req.sel] = 1'b0;
          end
        end
      end
      ST_SETUP: begin
        if (rom_edge) begin
          s_nxt.cs_n[s_r.sel] = 1'b0;
          s_nxt.rd            = !s_r.write;
          s_nxt.wr            = s_r.write;
          s_nxt.cnt = s_r.fast ? wait_of(cur_b, 1'b0)
                               : NORMAL_LEN;
          s_nxt.phase = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (rom_edge) begin
          if (s_r.cnt != 5'h00) begin
            s_nxt.cnt = s_r.cnt - 5'h01;
          end else if (s_r.fast || s_r.rdy_s2) begin
            s_nxt.phase = ST_STROBE;
          end
        end
      end
      ST_STROBE: begin
        if (rom_edge) begin
          if (s_r.beat_left != 4'h0 && (s_r.hold || s_r.burst)) begin
            s_nxt.addr      = s_r.addr + 4'h1;
            s_nxt.beat_left = s_r.beat_left - 4'h1;
            if (s_r.burst) begin
              s_nxt.cnt = wait_of(cur_b, 1'b1);
              if (s_nxt.cnt < BURST_MIN) begin
                s_nxt.cnt = BURST_MIN - 5'h01;
              end
            end else begin
              s_nxt.cnt = wait_of(cur_b, 1'b0);
            end
            s_nxt.phase = ST_WAIT;
          end else begin
            s_nxt.cs_n  = '1;
            s_nxt.rd    = 1'b0;
            s_nxt.wr    = 1'b0;
            s_nxt.phase = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        s_nxt.done  = 1'b1;
        s_nxt.phase = ST_IDLE;
      end
      default: begin
        s_nxt.phase = ST_IDLE;
      end
    endcase

    s_nxt.wide_oe = any_wide && (s_nxt.cs_n != '1) &&
                    is_wide(s_r.cfg[s_nxt.sel].cfg_a);

    if (sys_rst) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        s_nxt.cfg[i].cfg_a = rom_timing_pkg::RST_CFG_A;
        s_nxt.cfg[i].cfg_b = rom_timing_pkg::RST_CFG_B;
      end
      s_nxt.phase     = ST_IDLE;
      s_nxt.sel       = 2'h0;
      s_nxt.write     = 1'b0;
      s_nxt.fast      = 1'b0;
      s_nxt.early     = 1'b0;
      s_nxt.burst     = 1'b0;
      s_nxt.hold      = 1'b0;
      s_nxt.addr      = 4'h0;
      s_nxt.beat_left = 4'h0;
      s_nxt.cnt       = 5'h00;
      s_nxt.div       = 2'h0;
      s_nxt.rdy_s1    = 2'h0;
      s_nxt.rdy_s2    = 1'b0;
      s_nxt.cs_n      = '1;
      s_nxt.rd        = 1'b0;
      s_nxt.wr        = 1'b0;
      s_nxt.done      = 1'b0;
      s_nxt.event_out = 1'b0;
      s_nxt.qual_prev = 1'b0;
      s_nxt.wide_oe   = 1'b0;
      s_nxt.rdata     = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata                 = s_r.rdata;
  assign cpu_ready                 = s_r.done;
  assign rom_chip_select_n         = s_r.cs_n;
  assign rom_read_strobe           = s_r.rd;
  assign rom_write_strobe          = s_r.wr;
  assign system_address_low        = s_r.addr;
  assign wide_buffer_output_enable = s_r.wide_oe;
  assign rom_access_event          = s_r.event_out;
  assign rom_clk_enable            = (s_r.phase != ST_IDLE);

endmodule // rom_flash_access_timing

// ===== rom_timing_pkg.sv
// package: register indices, field layout and timing constants of the rom timing block
package rom_timing_pkg;

  // ---------------------------------------------------------------
  // register indices in the chip setup index space
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_SEL0_A = 8'h23;
  localparam logic [7:0] IDX_SEL0_B = 8'h24;
  localparam logic [7:0] IDX_SEL1_A = 8'h25;
  localparam logic [7:0] IDX_SEL1_B = 8'h26;
  localparam logic [7:0] IDX_SEL2_A = 8'h27;
  localparam logic [7:0] IDX_SEL2_B = 8'h28;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  // config a: [1:0] width code, [2] fast speed, [3] burst timing select,
  // [4] early chip select
  localparam int A_WIDTH_LO = 0;
  localparam int A_FAST     = 2;
  localparam int A_BURST    = 3;
  localparam int A_EARLY    = 4;
  // config b: [3:0] first access wait count, [7:4] burst wait count
  localparam int B_FIRST_LO = 0;
  localparam int B_BURST_LO = 4;

  localparam logic [7:0] RST_CFG_A = 8'h00;
  localparam logic [7:0] RST_CFG_B = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_MHZ   = 25;
  localparam int FAST_MAX_MHZ  = 33;
  localparam int BURST_MIN_NS  = 30;
  localparam int SYS_PERIOD_NS = 1000 / SYS_CLK_MHZ;
  // least burst address hold, rounded up, at least one cycle
  localparam int BURST_MIN_CYC_RAW =
    (BURST_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int BURST_MIN_CYC =
    (BURST_MIN_CYC_RAW < 1) ? 1 : BURST_MIN_CYC_RAW;
  // fast access divider so the rate never passes the cap
  localparam int FAST_DIV_RAW =
    (SYS_CLK_MHZ + FAST_MAX_MHZ - 1) / FAST_MAX_MHZ;
  localparam int FAST_DIV = (FAST_DIV_RAW < 1) ? 1 : FAST_DIV_RAW;
  // isa-style base length of a normal-speed strobe, in rom clocks
  localparam int NORMAL_CYC = 4;

  localparam logic [1:0] WIDTH_16 = 2'b10;
  localparam logic [1:0] WIDTH_32 = 2'b11;

  typedef struct packed {
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
  } sel_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       isa;
    logic       cacheable;
    logic       line_fill;
    logic [1:0] sel;
    logic [3:0] addr_low;
  } cpu_req_t;

endpackage : rom_timing_pkg

// ===== rom_timing_monitor.sv
// checker: port-level properties of the rom timing block
module rom_timing_monitor #(
  parameter int NUM_SEL = 3
) (
  input wire logic                     clk_sys,
  input wire logic                     sys_rst,
  input wire rom_timing_pkg::cpu_req_t cpu_req,
  input wire logic                     cpu_ready,
  input wire logic [NUM_SEL-1:0]       rom_chip_select_n,
  input wire logic                     rom_read_strobe,
  input wire logic                     rom_write_strobe,
  input wire logic                     rom_access_event,
  input wire logic                     rom_clk_enable
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic sel_on = ~&rom_chip_select_n;
  wire logic cmd = rom_read_strobe | rom_write_strobe;
  a_one_select: assert property ($onehot0(~rom_chip_select_n))
    else $error("two chip selects low together");
  a_strobe_excl: assert property (
    !(rom_read_strobe && rom_write_strobe))
    else $error("read and write strobes together");
  a_ready_pulse: assert property (cpu_ready |=> !cpu_ready)
    else $error("ready held past one cycle");
  a_event_cause: assert property (
    rom_access_event |-> $past(sel_on && cmd))
    else $error("access event without qualified select");
  a_event_fall: assert property (
    $rose(sel_on && cmd) |=> rom_access_event)
    else $error("qualified select gave no event");
  a_clk_busy: assert property ((sel_on || cmd) |-> rom_clk_enable)
    else $error("rom clock gated during access");
  a_isa_gated: assert property (
    (!rom_clk_enable && cpu_req.valid && cpu_req.isa) |=> !rom_clk_enable)
    else $error("isa request woke rom clock");
  a_write_cmd: assert property (
    rom_write_strobe |-> cpu_req.valid && cpu_req.write)
    else $error("write strobe without write request");
  a_read_cmd: assert property (
    rom_read_strobe |-> cpu_req.valid && !cpu_req.write)
    else $error("read strobe without read request");
endmodule // rom_timing_monitor

bind rom_flash_access_timing rom_timing_monitor #(.NUM_SEL(NUM_SEL))
  i_rom_timing_monitor (.clk_sys, .sys_rst, .cpu_req, .cpu_ready,
  .rom_chip_select_n, .rom_read_strobe, .rom_write_strobe,
  .rom_access_event, .rom_clk_enable);

// ===== rom_device_model.sv
// partner: isa-side party that stretches strobes through the ready line
module rom_device_model (
  input wire logic       clk_sys,
  input wire logic [2:0] rom_chip_select_n,
  input wire logic       rom_read_strobe,
  input wire logic       rom_write_strobe,
  input wire logic [31:0] stall,
  output logic           iochrdy_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial iochrdy_pin = 1'b1;
  // released line sits at its pull-up level
  always @(posedge clk_sys) begin
    if ((rom_read_strobe | rom_write_strobe) && ~&rom_chip_select_n &&
        cnt < stall) begin
      cnt <= cnt + 1;
      iochrdy_pin <= 1'b0;
    end else begin
      iochrdy_pin <= 1'b1;
      if (!(rom_read_strobe | rom_write_strobe)) cnt <= 0;
    end
  end
endmodule // rom_device_model

// ===== rom_flash_access_timing_tb_top.sv
// testbench: register access and rom cycle timing scenarios
module rom_flash_access_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_index = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, v;
  rom_timing_pkg::cpu_req_t cpu_req = '0;
  logic cpu_cache_en = 1'b0;
  logic cpu_ready, iochrdy_pin, rom_read_strobe, rom_write_strobe, rd_q;
  logic wr_q;
  logic wide_buffer_output_enable, rom_access_event, rom_clk_enable;
  logic [2:0] rom_chip_select_n, cs_q;
  logic [3:0] system_address_low, a_q;
  int n_fail = 0, n_checks = 0, stall = 0;
  int n_fall, n_evt, n_rd, n_addr, n_wide, n_wr, l0, l1, l2;
  always #20 clk_sys = ~clk_sys;
  rom_flash_access_timing i_rom_flash_access_timing (.clk_sys, .sys_rst,
    .reg_wr, .reg_index, .reg_wdata, .reg_rdata, .cpu_req, .cpu_cache_en,
    .cpu_ready, .iochrdy_pin, .rom_chip_select_n, .rom_read_strobe,
    .rom_write_strobe, .system_address_low, .wide_buffer_output_enable,
    .rom_access_event, .rom_clk_enable);
  rom_device_model i_rom_device_model (.clk_sys, .rom_chip_select_n,
    .rom_read_strobe, .rom_write_strobe, .stall, .iochrdy_pin);
  // ---------------------------------------------------------------
  // pin activity counters
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    cs_q <= rom_chip_select_n;
    a_q <= system_address_low;
    rd_q <= rom_read_strobe;
    wr_q <= rom_write_strobe;
    if (rom_write_strobe === 1'b1 && wr_q !== 1'b1) n_wr++;
    if (|(cs_q & ~rom_chip_select_n)) n_fall++;
    if (rom_access_event === 1'b1) n_evt++;
    if (wide_buffer_output_enable === 1'b1) n_wide++;
    if (rom_read_strobe === 1'b1 && rd_q !== 1'b1) n_rd++;
    if (~&rom_chip_select_n && system_address_low !== a_q) n_addr++;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clk_sys);
    reg_index = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
    @(negedge clk_sys);
    reg_index = idx;
    repeat (2) @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic cfg(input int s, input logic [7:0] a, input logic [7:0] b);
    wr_reg(rom_timing_pkg::IDX_SEL0_A + 8'(2 * s), a);
    wr_reg(rom_timing_pkg::IDX_SEL0_B + 8'(2 * s), b);
  endtask
  task automatic acc(input logic [1:0] s, input logic w, c, f, i,
                     output int lat);
    n_fall = 0;
    n_evt = 0;
    n_rd = 0;
    n_addr = 0;
    n_wide = 0;
    n_wr = 0;
    @(negedge clk_sys);
    cpu_req = {1'b1, w, i, c, f, s, 4'h0};
    lat = 0;
    do begin
      @(negedge clk_sys);
      lat++;
    end while (cpu_ready !== 1'b1 && lat < 300);
    cpu_req.valid = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int k = 0; k < 6; k++) begin
      rd_reg(8'h23 + 8'(k), v);
      check(v, 8'h00);
      wr_reg(8'h23 + 8'(k), 8'h11 + 8'(k));
      rd_reg(8'h23 + 8'(k), v);
      check(v, 8'h11 + 8'(k));
    end
    wr_reg(8'h29, 8'hff);
    rd_reg(8'h29, v);
    check(v, 8'h00);
    for (int k = 0; k < 3; k++) cfg(k, 8'h00, 8'h00);
    check(rom_clk_enable, 1'b0);
    acc(0, 0, 0, 0, 0, l0);
    check(n_fall, 1);
    check(n_rd, 1);
    check(n_evt, 1);
    cfg(0, 8'h00, 8'hff);
    acc(0, 0, 0, 0, 0, l1);
    check(l1, l0);
    stall = 6;
    acc(0, 0, 0, 0, 0, l1);
    stall = 0;
    check(l1 > l0, 1'b1);
    cfg(1, 8'h04, 8'h00);
    acc(1, 0, 0, 0, 0, l1);
    check(l1 < l0, 1'b1);
    cfg(1, 8'h04, 8'h03);
    acc(1, 0, 0, 0, 0, l2);
    check(l2 - l1, 3);
    cfg(2, 8'h03, 8'h00);
    acc(2, 0, 0, 0, 0, l2);
    check(l2, l1);
    check(n_wide, 0);
    cfg(0, 8'h13, 8'h00);
    acc(2, 0, 0, 0, 0, l2);
    check(n_wide > 0, 1'b1);
    cfg(0, 8'h10, 8'h00);
    acc(0, 1, 0, 0, 0, l2);
    check(n_fall, 1);
    check(n_evt, 1);
    check(n_wr, 1);
    check(n_rd, 0);
    cpu_cache_en = 1'b1;
    cfg(1, 8'h0e, 8'h02);
    acc(1, 0, 1, 1, 0, l1);
    cfg(1, 8'h0e, 8'h32);
    acc(1, 0, 1, 1, 0, l2);
    check(l2 - l1, 45);
    cfg(1, 8'h06, 8'h02);
    acc(1, 0, 1, 1, 0, l1);
    cfg(1, 8'h06, 8'h32);
    acc(1, 0, 1, 1, 0, l2);
    check(l2, l1);
    cfg(1, 8'h0e, 8'h02);
    acc(1, 0, 1, 0, 0, l1);
    check(n_fall, 1);
    check(n_rd, 1);
    check(n_addr > 2, 1'b1);
    cfg(1, 8'h0e, 8'h32);
    acc(1, 0, 1, 0, 0, l2);
    check(l2, l1);
    acc(0, 0, 0, 0, 1, l1);
    check(l1, 300);
    check(n_fall, 0);
    complete_run();
  end
endmodule // rom_flash_access_timing_tb_top
